// [src/nvbw_host.sv]
// Host controller driving a bytewide asynchronous nonvolatile memory.
// Assumes the memory pins are joined by the bench; data pins are split
// into input, output and output enable.

// Summary of operation
// - Host holds write data stable for setup before that end.
// - Host keeps select high at least the precharge time.
// - Host raises select within the maximum low time.
// - Host gives each access its own select falling edge.
// - Host takes no request while supply is out of tolerance.
// - 15-bit address selects one of 32768 bytes, 8 data bits.
// - Select low between 70 ns and 2000 ns each cycle.
module nvbw_host #(
  parameter int unsigned ACTIVE_CYC = nvbw_pkg::SELECT_ACTIVE_MIN_CYC,
  parameter int unsigned PRECH_CYC  = nvbw_pkg::PRECHARGE_MIN_CYC,
  parameter bit          WE_CTRL    = 1'b0
) (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic                        supply_ok,
  input  wire logic                        req_valid,
  input  wire logic                        req_write,
  input  wire logic [nvbw_pkg::ADDR_W-1:0] req_addr,
  input  wire logic [nvbw_pkg::DATA_W-1:0] req_wdata,
  output logic                             req_ready,
  output logic                             rsp_valid,
  output logic      [nvbw_pkg::DATA_W-1:0] rsp_rdata,
  output logic                             chip_select_n,
  output logic                             write_strobe_n,
  output logic                             output_drive_n,
  output logic      [nvbw_pkg::ADDR_W-1:0] address_lines,
  input  wire logic [nvbw_pkg::DATA_W-1:0] data_lines_in,
  output logic      [nvbw_pkg::DATA_W-1:0] data_lines_out,
  output logic                             data_lines_oe
);
  // Elaboration checks: refuse timing that the sequencer cannot serve
  // Select must stay low for the least active time
  if (ACTIVE_CYC < nvbw_pkg::SELECT_ACTIVE_MIN_CYC) begin : g_act_short
    $error("nvbw_host: select active time too short");
  end

  // Select must rise before the longest active time runs out
  if (ACTIVE_CYC > nvbw_pkg::SELECT_ACTIVE_MAX_CYC) begin : g_act_long
    $error("nvbw_host: select active time too long");
  end

  // Data must settle before the write ends; a late strobe costs a cycle
  if (ACTIVE_CYC < nvbw_pkg::DATA_SETUP_CYC + (WE_CTRL ? 2 : 1)) begin : g_setup_short
    $error("nvbw_host: no room for write data setup");
  end

  // Strobe needs one cycle of select before it may fall
  if (ACTIVE_CYC < 2) begin : g_act_min
    $error("nvbw_host: select active below two cycles");
  end

  // Select must stay high for the whole precharge
  if (PRECH_CYC < nvbw_pkg::PRECHARGE_MIN_CYC) begin : g_prech_short
    $error("nvbw_host: precharge too short");
  end

  // Phase counter must hold the longest phase
  if (ACTIVE_CYC >= (1 << nvbw_pkg::CNT_W) || PRECH_CYC >= (1 << nvbw_pkg::CNT_W)) begin : g_cnt_w
    $error("nvbw_host: phase counter too narrow");
  end

  // Last count of each phase
  localparam logic [nvbw_pkg::CNT_W-1:0] ACT_LAST = nvbw_pkg::CNT_W'(ACTIVE_CYC - 1);
  localparam logic [nvbw_pkg::CNT_W-1:0] PRE_LAST = nvbw_pkg::CNT_W'(PRECH_CYC - 1);

  // Write styles; the select style is decoded in two states, the strobe style only in the active state
  function automatic logic is_select_write(input logic wr);
    is_select_write = wr && !WE_CTRL;
  endfunction

  function automatic logic is_strobe_write(input logic wr);
    is_strobe_write = wr && WE_CTRL;
  endfunction

  // All controller state in one register
  typedef struct packed {
    nvbw_pkg::nvbw_state_e       state;
    logic [nvbw_pkg::CNT_W-1:0]  cnt;
    logic                        wr;
    logic                        req_ready;
    logic                        rsp_valid;
    logic [nvbw_pkg::DATA_W-1:0] rdata;
    logic                        cs_n;
    logic                        we_n;
    logic                        oe_n;
    logic [nvbw_pkg::ADDR_W-1:0] addr;
    logic [nvbw_pkg::DATA_W-1:0] dout;
    logic                        doe;
  } nvbw_host_s;

  // Registered state and its next value
  nvbw_host_s st_reg;
  nvbw_host_s st_next;
  logic [nvbw_pkg::DATA_W-1:0] din_sync;

  // Data pins come from outside the clock domain
  nvbw_sync #(
    .WIDTH (nvbw_pkg::DATA_W)
  ) u_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in (data_lines_in),
    .sync_out (din_sync)
  );

  // Cycle sequencer: setup, select-low access, select-high precharge
  always_comb begin
    st_next = st_reg;
    st_next.rsp_valid = 1'b0;
    case (st_reg.state)
      // Wait for a request; address and controls are set up on taking it
      nvbw_pkg::NVBW_IDLE: begin
        // No access while supply is bad; ready only then
        st_next.req_ready = supply_ok;
        if (req_valid && st_reg.req_ready && supply_ok) begin
          st_next.req_ready = 1'b0;
          st_next.wr        = req_write;
          st_next.addr      = req_addr;   // Set up one cycle before select falls
          st_next.dout      = req_wdata;
          st_next.doe       = 1'b0;
          // Select-controlled write: strobe low before select falls
          st_next.we_n      = !is_select_write(req_write);
          st_next.oe_n      = req_write;  // Reads enable the memory output
          st_next.state     = nvbw_pkg::NVBW_SETUP;
        end
      end
      // Address has settled; drop select to start the cycle
      nvbw_pkg::NVBW_SETUP: begin
        st_next.cs_n  = 1'b0;            // Own falling edge per access
        st_next.cnt   = '0;
        st_next.doe   = is_select_write(st_reg.wr); // Memory is released here
        st_next.state = nvbw_pkg::NVBW_ACTIVE;
      end
      // Select low; count out the active time
      nvbw_pkg::NVBW_ACTIVE: begin
        st_next.cnt = st_reg.cnt + 1'b1;
        // Strobe-controlled write: strobe falls one cycle after select
        if (is_strobe_write(st_reg.wr) && st_reg.cnt == '0) begin
          st_next.we_n = 1'b0;
        end
        // Drive only once the memory has released on strobe fall
        if (is_strobe_write(st_reg.wr) && !st_reg.we_n) begin
          st_next.doe = 1'b1;
        end
        if (st_reg.cnt == ACT_LAST) begin
          // Strobe and select rise together, ending the write
          st_next.cs_n  = 1'b1;
          st_next.we_n  = 1'b1;
          st_next.oe_n  = 1'b1;
          st_next.cnt   = '0;
          st_next.state = nvbw_pkg::NVBW_PRECH;
          if (!st_reg.wr) begin
            // Limitation: this is the pin two cycles back, so the active time
            // must cover the memory access time plus the synchroniser
            st_next.rdata     = din_sync;
            st_next.rsp_valid = 1'b1;
          end else begin
            st_next.rsp_valid = 1'b1;   // Write done within the bus cycle
          end
        end
      end
      // Select high; count out the precharge
      nvbw_pkg::NVBW_PRECH: begin
        // Hold data one cycle past select rise for hold time, then release
        st_next.doe = 1'b0;
        st_next.cnt = st_reg.cnt + 1'b1;
        if (st_reg.cnt == PRE_LAST) begin   // Select high for precharge
          st_next.state     = nvbw_pkg::NVBW_IDLE;
          st_next.req_ready = supply_ok;
        end
      end
      // Unused code: park with all pins idle
      default: begin
        st_next.state = nvbw_pkg::NVBW_IDLE;
        st_next.cs_n  = 1'b1;
        st_next.we_n  = 1'b1;
        st_next.oe_n  = 1'b1;
        st_next.doe   = 1'b0;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // Pins idle high, host not driving, not ready
      st_reg       <= '0;
      st_reg.state <= nvbw_pkg::NVBW_IDLE;
      st_reg.cs_n  <= 1'b1;
      st_reg.we_n  <= 1'b1;
      st_reg.oe_n  <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register
  assign req_ready      = st_reg.req_ready;
  assign rsp_valid      = st_reg.rsp_valid;
  assign rsp_rdata      = st_reg.rdata;
  assign chip_select_n  = st_reg.cs_n;
  assign write_strobe_n = st_reg.we_n;
  assign output_drive_n = st_reg.oe_n;
  assign address_lines  = st_reg.addr;  // Held while select is low; changes only when a request is taken
  assign data_lines_out = st_reg.dout;
  assign data_lines_oe  = st_reg.doe;
endmodule

// [src/nvbw_pkg.sv]
// Package for the bytewide nonvolatile memory host controller.
// Assumes a 20 MHz system clock; all pin timing is counted in its cycles.
package nvbw_pkg;
  // Clock period in ns
  localparam int unsigned CLK_PERIOD_NS       = 50;
  // Pin timing figures in ns
  localparam int unsigned SELECT_ACTIVE_MIN_NS = 70;
  localparam int unsigned SELECT_ACTIVE_MAX_NS = 2000;
  localparam int unsigned PRECHARGE_MIN_NS     = 60;
  localparam int unsigned DATA_SETUP_NS        = 30;
  localparam int unsigned ACCESS_TIME_NS       = 70;
  // Least times round up, longest round down, never below one cycle
  localparam int unsigned SELECT_ACTIVE_MIN_CYC =
    (SELECT_ACTIVE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SELECT_ACTIVE_MAX_CYC = SELECT_ACTIVE_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned PRECHARGE_MIN_CYC =
    (PRECHARGE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DATA_SETUP_CYC =
    (DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ACCESS_CYC =
    (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Bus geometry
  localparam int unsigned ADDR_W   = 15;
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned ROW_BYTES = 4;
  localparam int unsigned CNT_W    = 8;
  // Controller states
  typedef enum logic [2:0] {
    NVBW_IDLE   = 3'b000,
    NVBW_SETUP  = 3'b001,
    NVBW_ACTIVE = 3'b010,
    NVBW_PRECH  = 3'b011
  } nvbw_state_e;
endpackage

// [src/nvbw_sync.sv]
// Two-flop synchroniser bank for the data pins read back from the memory.
// Assumes the input arrives from outside the clock domain.
module nvbw_sync #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1_reg;

  // First stage is read only by the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_reg <= '0;
      sync_out   <= '0;
    end else begin
      stage1_reg <= async_in;
      sync_out   <= stage1_reg;
    end
  end
endmodule

// [tb/nvbw_host_chk.sv]
// Checker on the memory host pins, bound into nvbw_host.
// Assumes one clock with asynchronous active-low reset.
module nvbw_host_chk #(
  parameter int unsigned ACTIVE_CYC = 2,
  parameter int unsigned PRECH_CYC  = 2
) (
  input logic        clk,
  input logic        rst_n,
  input logic        supply_ok,
  input logic        req_ready,
  input logic        rsp_valid,
  input logic        chip_select_n,
  input logic        write_strobe_n,
  input logic        output_drive_n,
  input logic [14:0] address_lines,
  input logic [7:0]  data_lines_out,
  input logic        data_lines_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  int lo_cnt;
  int hi_cnt;
  // Select run lengths; int cannot wrap within a run
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lo_cnt <= 0;
      hi_cnt <= 0;
    end else begin
      lo_cnt <= chip_select_n ? 0 : lo_cnt + 1;
      hi_cnt <= chip_select_n ? hi_cnt + 1 : 0;
    end
  end
  AST_SEL_LEN: assert property ($rose(chip_select_n) |-> lo_cnt == ACTIVE_CYC)
    else $error("select low length wrong");
  AST_SEL_MAX: assert property ($fell(chip_select_n) |-> ##[1:40] chip_select_n)
    else $error("select held low too long");
  AST_PRECH: assert property ($fell(chip_select_n) |-> hi_cnt >= PRECH_CYC)
    else $error("precharge too short");
  AST_ADDR: assert property ($fell(chip_select_n) |-> $stable(address_lines))
    else $error("address moved at select fall");
  AST_WDATA: assert property (!chip_select_n && data_lines_oe |-> $stable(data_lines_out))
    else $error("write data moved");
  AST_WR_START: assert property ($fell(chip_select_n) && !write_strobe_n |->
    output_drive_n && data_lines_oe) else $error("write start wrong");
  AST_NO_FIGHT: assert property (!output_drive_n |-> !data_lines_oe)
    else $error("host drives during read");
  AST_RSP: assert property (rsp_valid |-> $rose(chip_select_n))
    else $error("answer not at select rise");
  AST_SUPPLY: assert property (!supply_ok |=> !req_ready)
    else $error("ready while supply bad");
  // Main scenarios reached
  cover property ($fell(chip_select_n) && !write_strobe_n);
  cover property ($fell(chip_select_n) && !output_drive_n);
  cover property (!supply_ok ##1 supply_ok);
  cover property (!chip_select_n && $fell(write_strobe_n));
endmodule

bind nvbw_host nvbw_host_chk #(.ACTIVE_CYC(ACTIVE_CYC), .PRECH_CYC(PRECH_CYC)) u_chk (
  .clk(clk), .rst_n(rst_n), .supply_ok(supply_ok), .req_ready(req_ready),
  .rsp_valid(rsp_valid), .chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n),
  .output_drive_n(output_drive_n), .address_lines(address_lines),
  .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe));

// [tb/nvbw_mem_model.sv]
// Behavioural bytewide nonvolatile memory.
// Assumes the bench resolves the data wire from both enables.
module nvbw_mem_model (
  input  logic        cs_n,
  input  logic        we_n,
  input  logic        oe_n,
  input  logic [14:0] addr,
  input  logic [7:0]  dq_in,
  output logic [7:0]  dq_out,
  output logic        dq_en
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  mem [0:32767];
  logic [14:0] lat;
  logic        wr;
  int          wear [0:8191];
  // Address fixed and cycle kind first set at select fall; never refused
  always @(negedge cs_n) begin
    lat = addr;
    wr = !we_n;
    wear[addr[14:2]]++;
  end
  // Late strobe turns the read into a write
  always @(negedge we_n) if (!cs_n) wr = 1;
  // First rising edge ends the write; no busy time after
  always @(posedge we_n or posedge cs_n) if (wr) begin
    mem[lat] = dq_in;
    wr = 0;
  end
  // Drive only in reads; released lines show the inverse, not a held value
  assign dq_en = !cs_n && !oe_n && we_n && !wr;
  assign dq_out = dq_en ? mem[lat] : ~mem[lat];
endmodule

// [tb/test_nvbw_host.sv]
// Bench for the memory host against a behavioural memory.
// Assumes a three-cycle select so read data clears the synchroniser.
module test_nvbw_host;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int AC = 3;
  logic        clk, rst_n, supply_ok, req_valid, req_write, req_ready, rsp_valid;
  logic        cs_n, we_n, oe_n, oe, m_en;
  logic [14:0] req_addr, addr;
  logic [7:0]  req_wdata, rsp_rdata, dout, m_out;
  logic [14:0] ads [4] = '{15'h0000, 15'h0003, 15'h0004, 15'h7fff};
  int          error_cnt = 0;
  int          compares = 0;
  wire  [7:0]  dq = oe ? dout : m_en ? m_out : ~dout;
  logic        cs2_n, we2_n, oe2_n, oe2, m2_en, req2_ready, rsp2_valid;
  logic [14:0] addr2;
  logic [7:0]  rsp2_rdata, dout2, m2_out;
  wire  [7:0]  dq2 = oe2 ? dout2 : m2_en ? m2_out : ~dout2;
  nvbw_host #(.ACTIVE_CYC(AC)) DUT (.clk(clk), .rst_n(rst_n), .supply_ok(supply_ok),
    .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .chip_select_n(cs_n), .write_strobe_n(we_n),
    .output_drive_n(oe_n), .address_lines(addr), .data_lines_in(dq),
    .data_lines_out(dout), .data_lines_oe(oe));
  nvbw_mem_model u_mem (.cs_n(cs_n), .we_n(we_n), .oe_n(oe_n), .addr(addr),
    .dq_in(dq), .dq_out(m_out), .dq_en(m_en));
  // Same requests into a strobe-controlled writer with its own memory
  nvbw_host #(.ACTIVE_CYC(AC), .WE_CTRL(1'b1)) DUT_WE (.clk(clk), .rst_n(rst_n),
    .supply_ok(supply_ok), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req2_ready),
    .rsp_valid(rsp2_valid), .rsp_rdata(rsp2_rdata), .chip_select_n(cs2_n),
    .write_strobe_n(we2_n), .output_drive_n(oe2_n), .address_lines(addr2),
    .data_lines_in(dq2), .data_lines_out(dout2), .data_lines_oe(oe2));
  nvbw_mem_model u_mem_we (.cs_n(cs2_n), .we_n(we2_n), .oe_n(oe2_n), .addr(addr2),
    .dq_in(dq2), .dq_out(m2_out), .dq_en(m2_en));
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
      error_cnt++;
    end
  endtask
  task automatic end_sim;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // One edge, with a bound on every wait
  task automatic tick(inout int n);
    @(posedge clk);
    #1 n++;
    if (n > 40) begin
      chk(8'h01, 8'h00);
      end_sim;
    end
  endtask
  // One access: answer time and read data
  task automatic acc(input logic w, input logic [14:0] ad, input logic [7:0] d);
    int n = 0;
    req_valid = 1;
    req_write = w;
    req_addr = ad;
    req_wdata = d;
    while (req_ready !== 1) tick(n);
    tick(n);
    req_valid = 0;
    n = 0;
    while (rsp_valid !== 1) tick(n);
    chk(8'(n), 8'(1 + AC));
    chk(8'({rsp2_valid, req2_ready}), 8'h02);
    if (!w) chk(rsp_rdata, d);
    if (!w) chk(rsp2_rdata, d);
  endtask
  // Back-to-back writes over a row edge and both address ends, then reads
  task automatic t_rw;
    for (int i = 0; i < 4; i++) acc(1, ads[i], 8'(i) ^ 8'ha5);
    for (int i = 0; i < 4; i++) acc(0, ads[i], 8'(i) ^ 8'ha5);
    chk(8'(u_mem.wear[0]), 8'h04);
    chk(8'(u_mem.wear[1]), 8'h02);
  endtask
  // Requests held off while the supply is bad
  task automatic t_supply;
    supply_ok = 0;
    req_valid = 1;
    repeat (6) begin
      @(posedge clk);
      #1 chk(8'({req_ready, cs_n}), 8'h01);
    end
    supply_ok = 1;
    acc(0, 15'h0004, 8'ha7);
  endtask
  // Reset in mid-read releases the pins; stored data survives
  task automatic t_reset;
    req_valid = 1;
    req_write = 0;
    repeat (4) @(posedge clk);
    #1 rst_n = 0;
    req_valid = 0;
    #1 chk(8'({cs_n, we_n, oe_n, oe, m_en}), 8'h1c);
    @(posedge clk);
    #1 rst_n = 1;
    acc(0, 15'h7fff, 8'ha6);
  endtask
  // Host and memory never both drive the data wire
  always @(negedge clk) chk(8'({oe & m_en, oe2 & m2_en}), 8'h00);
  initial begin
    rst_n = 0;
    supply_ok = 1;
    req_valid = 0;
    req_write = 0;
    req_addr = 15'h0000;
    req_wdata = 8'h00;
    repeat (2) @(posedge clk);
    #1 rst_n = 1;
    t_rw;
    t_supply;
    t_reset;
    end_sim;
  end
endmodule
